//--- src/emac_pkg.sv
package emac_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register map
   localparam int         REG_AW          = 16;
   localparam logic [15:0] OFS_ENABLE_ACK = 16'h0024;
   localparam logic [15:0] OFS_MEM_ATTR   = 16'h0028;

   ////////////////////////////////////////////////////////////////////////
   // enable_acknowledge field positions
   localparam int ACK_GTE_BIT  = 0;
   localparam int ACK_PRIQ_BIT = 1;
   localparam int ACK_EVQ_BIT  = 2;
   localparam int ACK_CMDQ_BIT = 3;
   localparam int ACK_W        = 4;
   localparam logic [ACK_W-1:0] ACK_RST = 4'h0;

   ////////////////////////////////////////////////////////////////////////
   // memory_attribute_control field positions
   localparam int ATTR_W     = 12;
   localparam int GRP_W      = 6;
   localparam int TBL_LSB    = 6;
   localparam int QUE_LSB    = 0;
   localparam int SH_LSB     = 4;
   localparam int OC_LSB     = 2;
   localparam int IC_LSB     = 0;
   localparam logic [ATTR_W-1:0] ATTR_RST = 12'h000;

   ////////////////////////////////////////////////////////////////////////
   // attribute encodings
   localparam logic [1:0] SH_NON   = 2'h0;
   localparam logic [1:0] SH_RSVD  = 2'h1;
   localparam logic [1:0] SH_OUTER = 2'h2;
   localparam logic [1:0] SH_INNER = 2'h3;
   localparam logic [1:0] CA_NC    = 2'h0;
   localparam logic [1:0] CA_WB    = 2'h1;
   localparam logic [1:0] CA_WT    = 2'h2;
   localparam logic [1:0] CA_RSVD  = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // structure sizes and preset values
   localparam int ECMDQ_NUM = 2;
   localparam logic [GRP_W-1:0] TBL_FIXED_VAL = 6'h25;
   localparam logic [GRP_W-1:0] QUE_FIXED_VAL = 6'h25;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage : emac_pkg

//--- src/emac_attr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface emac_attr_if;
   import emac_pkg::*;
   logic [GRP_W-1:0] raw;
   logic [1:0]       sh;
   logic [1:0]       oc;
   logic [1:0]       ic;
   logic             cacheable;
   modport dec (input raw, output sh, output oc, output ic, output cacheable);
   modport use_side (output raw, input sh, input oc, input ic,
                     input cacheable);
endinterface : emac_attr_if
`default_nettype wire

//--- src/emac_attr_dec.sv
`timescale 1ns/1ps
`default_nettype none
module emac_attr_dec (
   // attribute group
   emac_attr_if.dec a
);
   import emac_pkg::*;

   logic [1:0] sh_raw;
   logic [1:0] oc_raw;
   logic [1:0] ic_raw;

   assign sh_raw = a.raw[SH_LSB +: 2];
   assign oc_raw = a.raw[OC_LSB +: 2];
   assign ic_raw = a.raw[IC_LSB +: 2];

   always_comb begin
      a.oc = (oc_raw == CA_RSVD) ? CA_NC : oc_raw;
      a.ic = (ic_raw == CA_RSVD) ? CA_NC : ic_raw;
      // shareability means nothing for fully non-cacheable access
      if ((oc_raw == CA_NC) && (ic_raw == CA_NC)) begin
         a.sh = SH_OUTER;
      end else if (sh_raw == SH_RSVD) begin
         a.sh = SH_NON;
      end else begin
         a.sh = sh_raw;
      end
      a.cacheable = (a.oc != CA_NC) || (a.ic != CA_NC);
   end

endmodule : emac_attr_dec
`default_nettype wire

//--- src/emac_wr_guard.sv
`timescale 1ns/1ps
`default_nettype none
module emac_wr_guard (
   // enables and acknowledges
   input  wire logic                 gte,
   input  wire logic                 gte_ack,
   input  wire logic                 cmdq_en,
   input  wire logic                 cmdq_ack,
   input  wire logic                 evq_en,
   input  wire logic                 evq_ack,
   input  wire logic                 priq_en,
   input  wire logic [emac_pkg::ECMDQ_NUM-1:0] ecmdq_en,
   input  wire logic [emac_pkg::ECMDQ_NUM-1:0] ecmdq_ack,
   // write permission
   output logic                      tbl_wr_ok,
   output logic                      que_wr_ok
);
   import emac_pkg::*;

   assign tbl_wr_ok = !gte && !gte_ack;
   // pri ack is not part of the queue guard, only its enable
   assign que_wr_ok = !evq_en && !evq_ack && !cmdq_en && !cmdq_ack &&
                      !priq_en && !(|ecmdq_en) && !(|ecmdq_ack);

endmodule : emac_wr_guard
`default_nettype wire

//--- src/emac_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - page-queue ack bit shows page request queue enable; zero reset; zero unsupported.
// - ack bit 0 shows global translate enable; resets to zero.
// - enable_acknowledge sits at 0x0024, read-only, writes ignored.
// - table shareability decode; reserved as non; outer when both caches off.
// - table outer cacheability decode; reserved treated as non-cacheable.
// - table inner cacheability decode; reserved treated as non-cacheable.
// - queue shareability decoded like table; outer when queue caches off.
// - queue outer cacheability decode; reserved treated as non-cacheable.
// - queue inner cacheability decode; reserved treated as non-cacheable.
// - memory_attribute_control at 0x0028, read/write, fields individually guarded.
// - table fields reset to a fixed value only when preset flag set.
// - preset table fields store writes for readback; effective type fixed.
// - table fields writable only when global enable and its ack zero.
// - queue fields preset like table fields when queue preset flag set.
// - enhanced queue enables and acks also guard queue field writes.
// - queue field writes ignored while any guarding enable or ack set.
// - table attributes drive stream table; queue attributes drive queues.
// - base register allocation hints used only for cacheable types.
// - unsupported memory type aborts; stream fetch raises fetch fault.
// - ack bits 3 and 2 show command and event queue enables.
module emac_regs #(
   parameter bit PRI_SUPPORTED         = 1'b1,
   parameter bit TABLE_ATTRS_FIXED     = 1'b0,
   parameter bit QUEUE_ATTRS_FIXED     = 1'b0,
   parameter bit WT_SUPPORTED          = 1'b1
) (
   // clock and reset
   input  wire logic                           clk_sys,
   input  wire logic                           rstn,
   // register access
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   input  wire logic [emac_pkg::REG_AW-1:0]    reg_addr,
   input  wire logic [31:0]                    reg_wdata,
   output logic [31:0]                         reg_rdata,
   output logic                                reg_rvalid,
   // enable_control requests
   input  wire logic                           global_translate_enable,
   input  wire logic                           command_queue_enable,
   input  wire logic                           event_queue_enable,
   input  wire logic                           page_req_queue_enable,
   input  wire logic [emac_pkg::ECMDQ_NUM-1:0] enhanced_cmdq_enable,
   input  wire logic [emac_pkg::ECMDQ_NUM-1:0] enhanced_cmdq_enable_ack,
   // stream table fetch
   input  wire logic                           stream_table_fetch_req,
   // acknowledge state
   output logic [emac_pkg::ACK_W-1:0]          enable_acknowledge,
   // effective table attributes
   output logic [1:0]                          table_shareability_eff,
   output logic [1:0]                          table_outer_cacheability_eff,
   output logic [1:0]                          table_inner_cacheability_eff,
   output logic                                table_hint_use,
   // effective queue attributes
   output logic [1:0]                          queue_shareability_eff,
   output logic [1:0]                          queue_outer_cacheability_eff,
   output logic [1:0]                          queue_inner_cacheability_eff,
   output logic                                queue_hint_use,
   // access faults
   output logic                                table_type_abort,
   output logic                                queue_type_abort,
   output logic                                stream_entry_fetch_fault
);
   import emac_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic [ACK_W-1:0]  ack;
      logic [ATTR_W-1:0] attr;
      logic [31:0]       rdata;
      logic              rvalid;
      logic [GRP_W-1:0]  tbl_eff;
      logic              tbl_hint;
      logic [GRP_W-1:0]  que_eff;
      logic              que_hint;
      logic              tbl_abort;
      logic              que_abort;
      logic              fetch_fault;
   } emac_st_s;

   // undefined reset of non-preset fields is taken as zero here
   localparam logic [ATTR_W-1:0] ATTR_INIT =
      {(TABLE_ATTRS_FIXED ? TBL_FIXED_VAL : ATTR_RST[TBL_LSB +: GRP_W]),
       (QUEUE_ATTRS_FIXED ? QUE_FIXED_VAL : ATTR_RST[QUE_LSB +: GRP_W])};

   localparam emac_st_s ST_RST = '{
      ack:         ACK_RST,
      attr:        ATTR_INIT,
      rdata:       RDATA_ZERO,
      rvalid:      1'b0,
      tbl_eff:     6'h00,
      tbl_hint:    1'b0,
      que_eff:     6'h00,
      que_hint:    1'b0,
      tbl_abort:   1'b0,
      que_abort:   1'b0,
      fetch_fault: 1'b0
   };

   emac_st_s st_r;
   emac_st_s st_nxt;

   ////////////////////////////////////////////////////////////////////////
   // write guard and decoders

   logic tbl_wr_ok;
   logic que_wr_ok;

   emac_wr_guard u_guard (
      .gte       (global_translate_enable),
      .gte_ack   (st_r.ack[ACK_GTE_BIT]),
      .cmdq_en   (command_queue_enable),
      .cmdq_ack  (st_r.ack[ACK_CMDQ_BIT]),
      .evq_en    (event_queue_enable),
      .evq_ack   (st_r.ack[ACK_EVQ_BIT]),
      .priq_en   (page_req_queue_enable),
      .ecmdq_en  (enhanced_cmdq_enable),
      .ecmdq_ack (enhanced_cmdq_enable_ack),
      .tbl_wr_ok (tbl_wr_ok),
      .que_wr_ok (que_wr_ok)
   );

   emac_attr_if tbl_if ();
   emac_attr_if que_if ();

   // preset groups keep their fixed type whatever the stored value says
   assign tbl_if.raw = TABLE_ATTRS_FIXED ? TBL_FIXED_VAL
                                         : st_r.attr[TBL_LSB +: GRP_W];
   assign que_if.raw = QUEUE_ATTRS_FIXED ? QUE_FIXED_VAL
                                         : st_r.attr[QUE_LSB +: GRP_W];

   emac_attr_dec u_tbl_dec (
      .a (tbl_if.dec)
   );

   emac_attr_dec u_que_dec (
      .a (que_if.dec)
   );

   ////////////////////////////////////////////////////////////////////////
   // next state

   logic wr_attr;
   logic rd_ack;
   logic rd_attr;
   logic tbl_unsup;
   logic que_unsup;

   assign wr_attr = reg_wr && (reg_addr == OFS_MEM_ATTR);
   assign rd_ack  = reg_addr == OFS_ENABLE_ACK;
   assign rd_attr = reg_addr == OFS_MEM_ATTR;

   // write-through is the only type a build may leave out
   assign tbl_unsup = !WT_SUPPORTED &&
                      ((tbl_if.oc == CA_WT) || (tbl_if.ic == CA_WT));
   assign que_unsup = !WT_SUPPORTED &&
                      ((que_if.oc == CA_WT) || (que_if.ic == CA_WT));

   always_comb begin
      st_nxt = st_r;

      // acknowledges follow their enables one cycle later
      st_nxt.ack[ACK_GTE_BIT]  = global_translate_enable;
      st_nxt.ack[ACK_EVQ_BIT]  = event_queue_enable;
      st_nxt.ack[ACK_CMDQ_BIT] = command_queue_enable;
      st_nxt.ack[ACK_PRIQ_BIT] = PRI_SUPPORTED && page_req_queue_enable;

      // guarded field writes; refused writes vanish silently
      if (wr_attr && tbl_wr_ok) begin
         st_nxt.attr[TBL_LSB +: GRP_W] = reg_wdata[TBL_LSB +: GRP_W];
      end
      if (wr_attr && que_wr_ok) begin
         st_nxt.attr[QUE_LSB +: GRP_W] = reg_wdata[QUE_LSB +: GRP_W];
      end

      // read port; a write to the ack offset changes nothing
      st_nxt.rvalid = reg_rd;
      st_nxt.rdata  = RDATA_ZERO;
      if (reg_rd && rd_ack) begin
         st_nxt.rdata[ACK_W-1:0] = st_r.ack;
      end else if (reg_rd && rd_attr) begin
         st_nxt.rdata[ATTR_W-1:0] = st_r.attr;
      end

      // effective attributes seen by the walkers
      st_nxt.tbl_eff  = {tbl_if.sh, tbl_if.oc, tbl_if.ic};
      st_nxt.que_eff  = {que_if.sh, que_if.oc, que_if.ic};
      st_nxt.tbl_hint = tbl_if.cacheable;
      st_nxt.que_hint = que_if.cacheable;

      st_nxt.tbl_abort   = tbl_unsup;
      st_nxt.que_abort   = que_unsup;
      st_nxt.fetch_fault = stream_table_fetch_req && tbl_unsup;
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign reg_rdata                = st_r.rdata;
   assign reg_rvalid               = st_r.rvalid;
   assign enable_acknowledge       = st_r.ack;
   assign table_shareability_eff             = st_r.tbl_eff[SH_LSB +: 2];
   assign table_outer_cacheability_eff             = st_r.tbl_eff[OC_LSB +: 2];
   assign table_inner_cacheability_eff             = st_r.tbl_eff[IC_LSB +: 2];
   assign table_hint_use           = st_r.tbl_hint;
   assign queue_shareability_eff             = st_r.que_eff[SH_LSB +: 2];
   assign queue_outer_cacheability_eff             = st_r.que_eff[OC_LSB +: 2];
   assign queue_inner_cacheability_eff             = st_r.que_eff[IC_LSB +: 2];
   assign queue_hint_use           = st_r.que_hint;
   assign table_type_abort         = st_r.tbl_abort;
   assign queue_type_abort         = st_r.que_abort;
   assign stream_entry_fetch_fault = st_r.fetch_fault;

endmodule : emac_regs
`default_nettype wire

//--- tb/emac_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module emac_regs_props
   import emac_pkg::*;
(
   // clock, reset and register access
   input wire logic                 clk_sys,
   input wire logic                 rstn,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire logic [REG_AW-1:0]    reg_addr,
   input wire logic [31:0]          reg_rdata,
   input wire logic                 reg_rvalid,
   // enables and observed state
   input wire logic                 global_translate_enable,
   input wire logic                 command_queue_enable,
   input wire logic                 event_queue_enable,
   input wire logic                 page_req_queue_enable,
   input wire logic [ECMDQ_NUM-1:0] enhanced_cmdq_enable,
   input wire logic [ECMDQ_NUM-1:0] enhanced_cmdq_enable_ack,
   input wire logic                 stream_table_fetch_req,
   input wire logic [ACK_W-1:0]     enable_acknowledge,
   input wire logic [1:0]           table_shareability_eff,
   input wire logic [1:0]           table_outer_cacheability_eff,
   input wire logic [1:0]           table_inner_cacheability_eff,
   input wire logic [1:0]           queue_shareability_eff,
   input wire logic [1:0]           queue_outer_cacheability_eff,
   input wire logic [1:0]           queue_inner_cacheability_eff,
   input wire logic                 table_type_abort,
   input wire logic                 stream_entry_fetch_fault
);
   logic [2:0] q_en;
   logic       que_busy;
   assign q_en = {command_queue_enable, event_queue_enable,
                  page_req_queue_enable};
   // pri ack is no guard, only its enable is
   assign que_busy = (|q_en) | (|enable_acknowledge[3:2])
      | (|enhanced_cmdq_enable) | (|enhanced_cmdq_enable_ack);

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////
   rvalid_follow_a: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered next cycle");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not zero without a read");
   ack_global_a: assert property ($past(rstn) |->
      enable_acknowledge[0] == $past(global_translate_enable))
      else $error("global ack does not follow enable");
   ack_queue_a: assert property ($past(rstn) |->
      enable_acknowledge[3:1] == $past(q_en))
      else $error("queue acks do not follow enables");
   ack_read_a: assert property (reg_rd && reg_addr == OFS_ENABLE_ACK
      |=> reg_rdata == {28'h0000000, $past(enable_acknowledge)})
      else $error("ack register read back wrong");
   // decoded outputs lag the register by one cycle, hence the extra delay
   tbl_guard_a: assert property (reg_wr && reg_addr == OFS_MEM_ATTR
      && (global_translate_enable || enable_acknowledge[0])
      |=> ##1 $stable({table_shareability_eff, table_outer_cacheability_eff, table_inner_cacheability_eff}))
      else $error("guarded table write took effect");
   que_guard_a: assert property (reg_wr && reg_addr == OFS_MEM_ATTR
      && que_busy |=> ##1 $stable({queue_shareability_eff, queue_outer_cacheability_eff,
      queue_inner_cacheability_eff}))
      else $error("guarded queue write took effect");
   // both flops load from the same unsupported-type term on the fetch edge
   fetch_fault_a: assert property (stream_table_fetch_req
      |=> stream_entry_fetch_fault == table_type_abort)
      else $error("fetch fault does not match type abort");
endmodule // emac_regs_props
`default_nettype wire

//--- tb/emac_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
   fails++; $display("unexpected %0t got %0h exp %0h", $time, (a), (e)); \
   end end
////////////////////////////////////////////////////////////////////////////
module emac_regs_tb;
   import emac_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rstn = 1'b0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        fetch = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic [31:0] d;
   logic [31:0] rdata_f;
   logic [31:0] df;
   logic        rvalid;
   logic        fault;
   logic        t_hint;
   logic        q_hint;
   logic        t_abort;
   logic        q_abort;
   logic [5:0]  tf_eff;
   logic [5:0]  qf_eff;
   logic [7:0]  en = 8'h00;
   logic [3:0]  ack;
   logic [5:0]  t_eff;
   logic [5:0]  q_eff;
   int          fails = 0;
   int          check_count = 0;

   always #10 clk_sys = ~clk_sys;
   // write-through unsupported so the fetch fault path can be reached
   emac_regs #(.WT_SUPPORTED(1'b0)) dut (
      .clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
      .reg_rvalid(rvalid), .global_translate_enable(en[0]),
      .command_queue_enable(en[3]), .event_queue_enable(en[2]),
      .page_req_queue_enable(en[1]), .enhanced_cmdq_enable(en[5:4]),
      .enhanced_cmdq_enable_ack(en[7:6]), .stream_table_fetch_req(fetch),
      .enable_acknowledge(ack), .table_shareability_eff(t_eff[5:4]),
      .table_outer_cacheability_eff(t_eff[3:2]), .table_inner_cacheability_eff(t_eff[1:0]),
      .table_hint_use(t_hint), .queue_shareability_eff(q_eff[5:4]),
      .queue_outer_cacheability_eff(q_eff[3:2]), .queue_inner_cacheability_eff(q_eff[1:0]),
      .queue_hint_use(q_hint), .table_type_abort(t_abort),
      .queue_type_abort(q_abort),
      .stream_entry_fetch_fault(fault));
   // preset build: fixed types, stored values kept only for readback
   emac_regs #(.TABLE_ATTRS_FIXED(1'b1), .QUEUE_ATTRS_FIXED(1'b1)) dut_fx (
      .clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata_f),
      .reg_rvalid(), .global_translate_enable(en[0]),
      .command_queue_enable(en[3]), .event_queue_enable(en[2]),
      .page_req_queue_enable(en[1]), .enhanced_cmdq_enable(en[5:4]),
      .enhanced_cmdq_enable_ack(en[7:6]), .stream_table_fetch_req(fetch),
      .enable_acknowledge(), .table_shareability_eff(tf_eff[5:4]),
      .table_outer_cacheability_eff(tf_eff[3:2]), .table_inner_cacheability_eff(tf_eff[1:0]),
      .table_hint_use(), .queue_shareability_eff(qf_eff[5:4]),
      .queue_outer_cacheability_eff(qf_eff[3:2]), .queue_inner_cacheability_eff(qf_eff[1:0]),
      .queue_hint_use(), .table_type_abort(), .queue_type_abort(),
      .stream_entry_fetch_fault());
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [1:0] cad(input logic [1:0] c);
      return (c == CA_RSVD) ? CA_NC : c;
   endfunction
   function automatic logic [5:0] dec(input logic [5:0] g);
      logic [1:0] sh;
      sh = (g[5:4] == SH_RSVD) ? SH_NON : g[5:4];
      if (g[3:0] == 4'h0) sh = SH_OUTER;
      return {sh, cad(g[3:2]), cad(g[1:0])};
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      reg_wr = 1'b1;
      addr = a;
      wdata = v;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [15:0] a);
      reg_rd = 1'b1;
      addr = a;
      tick(1);
      reg_rd = 1'b0;
      `CHK(rvalid, 1'b1)
      d = rdata;
      df = rdata_f;
      tick(1);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd(OFS_ENABLE_ACK);
      `CHK(d, RDATA_ZERO)
      rd(OFS_MEM_ATTR);
      `CHK(d, RDATA_ZERO)
      `CHK({t_eff[5:4], q_eff[5:4]}, {SH_OUTER, SH_OUTER})
      $display("reset values done");
   endtask
   task automatic t_preset();
      rd(OFS_MEM_ATTR);
      `CHK(df, {20'h00000, TBL_FIXED_VAL, QUE_FIXED_VAL})
      wr(OFS_MEM_ATTR, 32'h0000_0FFF);
      rd(OFS_MEM_ATTR);
      `CHK(df, 32'h0000_0FFF)
      `CHK(tf_eff, dec(TBL_FIXED_VAL))
      `CHK(qf_eff, dec(QUE_FIXED_VAL))
      $display("preset values done");
   endtask
   task automatic t_ack();
      for (int i = 0; i < 4; i++) begin
         en = 8'h01 << i;
         tick(1);
         `CHK(ack, en[3:0])
         wr(OFS_ENABLE_ACK, 32'hFFFF_FFFF);
         rd(OFS_ENABLE_ACK);
         `CHK(d, {28'h0000000, en[3:0]})
      end
      en = 8'h00;
      rd(16'h002C);
      `CHK(d, RDATA_ZERO)
      $display("acknowledge done");
   endtask
   task automatic t_decode();
      logic [5:0] g;
      for (int i = 0; i < 64; i++) begin
         g = i[5:0];
         wr(OFS_MEM_ATTR, {20'hFFFFF, g, ~g});
         rd(OFS_MEM_ATTR);
         `CHK(d, {20'h00000, g, ~g})
         `CHK(t_eff, dec(g))
         `CHK(q_eff, dec(~g))
         fetch = 1'b1;
         tick(1);
         fetch = 1'b0;
         `CHK(fault, g[3:2] == CA_WT || g[1:0] == CA_WT)
         `CHK(t_abort, g[3:2] == CA_WT || g[1:0] == CA_WT)
         `CHK(q_abort, ~g[3:2] == CA_WT || ~g[1:0] == CA_WT)
         `CHK(t_hint, cad(g[3:2]) != CA_NC || cad(g[1:0]) != CA_NC)
         `CHK(q_hint, cad(~g[3:2]) != CA_NC || cad(~g[1:0]) != CA_NC)
      end
      $display("decode done");
   endtask
   task automatic t_guard();
      wr(OFS_MEM_ATTR, 32'h0000_0555);
      en = 8'h01;
      tick(2);
      wr(OFS_MEM_ATTR, 32'h0000_0AAA);
      // enable dropped but ack still high at the write edge
      en = 8'h00;
      wr(OFS_MEM_ATTR, 32'h0000_0FFF);
      rd(OFS_MEM_ATTR);
      `CHK(d, 32'h0000_057F)
      for (int i = 1; i < 8; i++) begin
         wr(OFS_MEM_ATTR, 32'h0000_0000);
         en = 8'h01 << i;
         tick(2);
         wr(OFS_MEM_ATTR, 32'h0000_0FFF);
         en = 8'h00;
         rd(OFS_MEM_ATTR);
         `CHK(d, 32'h0000_0FC0)
      end
      // enable already low, its ack still high at the write edge
      for (int i = 2; i < 4; i++) begin
         wr(OFS_MEM_ATTR, 32'h0000_0000);
         en = 8'h01 << i;
         tick(2);
         en = 8'h00;
         wr(OFS_MEM_ATTR, 32'h0000_0FFF);
         rd(OFS_MEM_ATTR);
         `CHK(d, 32'h0000_0FC0)
      end
      $display("write guards done");
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      tick(20);
      rstn = 1'b1;
      t_reset();
      t_preset();
      t_ack();
      t_decode();
      t_guard();
      rstn = 1'b0;
      tick(2);
      rstn = 1'b1;
      t_reset();
      t_preset();
      final_report();
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      fails++;
      final_report();
   end
endmodule // emac_regs_tb
bind emac_regs emac_regs_props props (
   .clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .global_translate_enable(global_translate_enable),
   .command_queue_enable(command_queue_enable),
   .event_queue_enable(event_queue_enable),
   .page_req_queue_enable(page_req_queue_enable),
   .enhanced_cmdq_enable(enhanced_cmdq_enable),
   .enhanced_cmdq_enable_ack(enhanced_cmdq_enable_ack),
   .stream_table_fetch_req(stream_table_fetch_req),
   .enable_acknowledge(enable_acknowledge),
   .table_shareability_eff(table_shareability_eff), .table_outer_cacheability_eff(table_outer_cacheability_eff),
   .table_inner_cacheability_eff(table_inner_cacheability_eff), .queue_shareability_eff(queue_shareability_eff),
   .queue_outer_cacheability_eff(queue_outer_cacheability_eff), .queue_inner_cacheability_eff(queue_inner_cacheability_eff),
   .table_type_abort(table_type_abort),
   .stream_entry_fetch_fault(stream_entry_fetch_fault));
`default_nettype wire
